//--- core/tos_pkg.sv
// package: constants of the timestamped output scheduler
package tos_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_AREA      = 8'h00;
  localparam logic [7:0] OFS_AREA_END  = 8'h3c;
  localparam logic [7:0] OFS_CFG       = 8'h40;
  localparam logic [7:0] OFS_COMMIT    = 8'h44;
  localparam logic [7:0] OFS_STATUS    = 8'h48;
  localparam logic [7:0] OFS_TICK      = 8'h4c;
  localparam logic [7:0] OFS_OUTS      = 8'h50;
  // output area and queue sizes
  localparam int         AREA_WORDS    = 15;
  localparam logic [3:0] ENTRIES_SMALL = 4'h5;
  localparam logic [3:0] ENTRIES_LARGE = 4'hf;
  localparam int         Q_DEPTH       = 31;
  // entry word fields
  localparam int         F_ST0         = 7;
  localparam int         F_ST1         = 6;
  localparam int         F_EN0         = 5;
  localparam int         F_EN1         = 4;
  localparam int         F_SEQ_LSB     = 8;
  localparam int         F_END         = 14;
  localparam int         F_TIME_LSB    = 16;
  // sequence and status encodings
  localparam logic [5:0] SEQ_RST       = 6'h01;
  localparam logic [7:0] STS_OK        = 8'h00;
  localparam logic [7:0] STS_SEQ       = 8'h01;
  localparam logic [7:0] STS_NONE      = 8'h02;
  localparam logic [7:0] STS_FULL      = 8'h03;
  localparam logic [7:0] STS_END_FLAG  = 8'h80;
  localparam logic [1:0] LAST_TAG      = 2'h1;
  localparam logic [1:0] NEXT_TAG      = 2'h3;
  // configuration
  localparam logic [7:0] CFG_RST       = 8'h00;
  localparam int         CFG_LARGE     = 0;
  // timing
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         US_NS         = 1000;
  localparam int         US_CYCLES     = US_NS / CLK_PERIOD_NS;
  localparam int         FLASH_HALF_US = 250000;
endpackage

//--- core/tos_q_if.sv
// interface: entry queue port between controller and queue store
`timescale 1ns/10ps
`default_nettype none
interface tos_q_if;
  logic        push;
  logic [31:0] wdata;
  logic        pop;
  logic [31:0] head;
  logic        empty;
  logic        full;
  logic [5:0]  count;
  modport ctrl  (output push, wdata, pop, input head, empty, full, count);
  modport store (input push, wdata, pop, output head, empty, full, count);
endinterface
`default_nettype wire

//--- core/tos_queue.sv
// module: circular store of timed entries in arrival order
`timescale 1ns/10ps
`default_nettype none
module tos_queue (
  input wire logic clk,
  input wire logic rst_n,
  tos_q_if.store   q
);
  logic [31:0] mem [tos_pkg::Q_DEPTH];
  logic [4:0]  wr_r;
  logic [4:0]  wr_nxt;
  logic [4:0]  rd_r;
  logic [4:0]  rd_nxt;
  logic [5:0]  cnt_r;
  logic [5:0]  cnt_nxt;
  logic        push_ok;
  logic        pop_ok;

  function automatic logic [4:0] ptr_inc(input logic [4:0] p);
    return (p == 5'(tos_pkg::Q_DEPTH - 1)) ? 5'h00 : p + 5'h01;
  endfunction

  always_comb
  begin
    push_ok = q.push && (cnt_r != 6'(tos_pkg::Q_DEPTH));
    pop_ok  = q.pop && (cnt_r != 6'h00);
    wr_nxt  = push_ok ? ptr_inc(wr_r) : wr_r;
    rd_nxt  = pop_ok ? ptr_inc(rd_r) : rd_r;
    cnt_nxt = cnt_r + 6'(push_ok) - 6'(pop_ok);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_r  <= 5'h00;
      rd_r  <= 5'h00;
      cnt_r <= 6'h00;
    end
    else
    begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push_ok)
      mem[wr_r] <= q.wdata;
  end

  assign q.head  = mem[rd_r];
  assign q.empty = (cnt_r == 6'h00);
  assign q.full  = (cnt_r == 6'(tos_pkg::Q_DEPTH));
  assign q.count = cnt_r;

  AST_CAP: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_r <= 6'(tos_pkg::Q_DEPTH))
    else $error("queue holds more than its depth");
  AST_CNT: assert property (@(posedge clk) disable iff (!rst_n)
    (q.push && !q.full && !q.pop) |=> cnt_r == $past(cnt_r) + 6'h01)
    else $error("count did not follow an enqueue");
endmodule // tos_queue
`default_nettype wire

//--- core/tos_top.sv
// module: timestamped two-channel output scheduler with AHB-Lite registers
// Contract
// - apply each queued entry's output states at its time value
// - two output channels, each with state, enable and indicator
// - each timed entry is four bytes: state, sequence number, time
// - device stores the entry combined by the controller from the area
// - output area holds five or fifteen entries, chosen by configuration
// - queue holds at most thirty-one entries
// - when full, further entries are refused, queue unchanged
// - fault indicator lit steadily on overload, short or overtemperature
// - fault indicator flashes on erroneous configuration
// - sequence number starts at 1, 0..63, non-following entries ignored
// - status 00 ok, 01 sequence, 02 none, 03 full, bit 7 end queued
// - 32-bit microsecond ticker from reset, entries compare low 16 bits
// - entries after one with sequence bit 6 set are ignored; the scan stops at such an entry only once it is queued
`timescale 1ns/10ps
`default_nettype none
module tos_top #(
  parameter int unsigned FLASH_HALF_US = tos_pkg::FLASH_HALF_US
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        fault_overload,
  input  wire logic        fault_short,
  input  wire logic        fault_overtemp,
  output logic [1:0]       do_state,
  output logic [1:0]       do_enable,
  output logic [1:0]       chan_led,
  output logic             module_fault_indicator
);
  typedef enum logic [0:0] {
    TOS_IDLE = 1'b0,
    TOS_SCAN = 1'b1
  } tos_scan_t;

  tos_q_if q ();

  tos_queue u_queue (
    .clk   (hclk),
    .rst_n (hresetn),
    .q     (q.store)
  );

  // bus slave
  logic        ap_ok;
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic [31:0] rd_val;
  logic [31:0] area_r [tos_pkg::AREA_WORDS];
  logic [7:0]  cfg_r;
  logic [7:0]  cfg_nxt;
  logic        cfg_err;
  logic        area_hit;
  logic        commit_hit;

  // scan engine
  tos_scan_t   st_r;
  tos_scan_t   st_nxt;
  logic [3:0]  idx_r;
  logic [3:0]  idx_nxt;
  logic [3:0]  limit;
  logic [5:0]  exp_r;
  logic [5:0]  exp_nxt;
  logic [5:0]  last_r;
  logic [5:0]  last_nxt;
  logic        bad_r;
  logic        bad_nxt;
  logic        pushed_r;
  logic        pushed_nxt;
  logic [7:0]  sts_r;
  logic [7:0]  sts_nxt;
  logic [5:0]  end_cnt_r;
  logic [5:0]  end_cnt_nxt;
  logic [31:0] cur;
  logic [5:0]  cur_seq;
  logic        cur_end;
  logic [7:0]  queue_status;
  logic [5:0]  next_seq;

  // ticker, outputs and fault indication
  logic [4:0]  div_r;
  logic [4:0]  div_nxt;
  logic        us_tick;
  logic [31:0] us_cnt_r;
  logic [31:0] us_cnt_nxt;
  logic [1:0]  st_out_r;
  logic [1:0]  st_out_nxt;
  logic [1:0]  en_out_r;
  logic [1:0]  en_out_nxt;
  logic [1:0]  head_st;
  logic [2:0]  s1_r;
  logic [2:0]  s2_r;
  logic [2:0]  s3_r;
  logic [2:0]  flt_r;
  logic [2:0]  flt_nxt;
  logic        fault_any;
  logic [19:0] fl_cnt_r;
  logic [19:0] fl_cnt_nxt;
  logic        fl_ph_r;
  logic        fl_ph_nxt;
  logic        mf_r;
  logic        mf_nxt;

  assign ap_ok      = hsel && htrans[1] && hready;
  assign area_hit   = wr_pend_r && (wr_addr_r < tos_pkg::OFS_AREA_END);
  assign commit_hit = wr_pend_r && (wr_addr_r == tos_pkg::OFS_COMMIT);
  assign cfg_err    = |cfg_r[7:1];
  assign limit      = cfg_r[tos_pkg::CFG_LARGE] ? tos_pkg::ENTRIES_LARGE
                                                : tos_pkg::ENTRIES_SMALL;

  assign queue_status = sts_r | ((end_cnt_r != 6'h00) ?
                        tos_pkg::STS_END_FLAG : 8'h00);
  assign next_seq     = q.empty ? exp_r : q.head[13:8];

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (haddr[7:0] < tos_pkg::OFS_AREA_END)
      rd_val = area_r[haddr[5:2]];
    else
      unique case (haddr[7:0])
        tos_pkg::OFS_CFG:    rd_val = {24'h000000, cfg_r};
        tos_pkg::OFS_STATUS: rd_val = {2'h0, q.count, queue_status,
                                       tos_pkg::NEXT_TAG, next_seq,
                                       tos_pkg::LAST_TAG, last_r};
        tos_pkg::OFS_TICK:   rd_val = us_cnt_r;
        tos_pkg::OFS_OUTS:   rd_val = {23'h000000, flt_r, en_out_r,
                                       st_out_r, 1'b0, mf_r};
        default:             rd_val = 32'h0000_0000;
      endcase
  end

  always_comb
  begin
    wr_pend_nxt = ap_ok && hwrite;
    wr_addr_nxt = ap_ok ? haddr[7:0] : wr_addr_r;
    hrdata_nxt  = (ap_ok && !hwrite) ? rd_val : 32'h0000_0000;
    cfg_nxt     = (wr_pend_r && wr_addr_r == tos_pkg::OFS_CFG) ?
                  hwdata[7:0] : cfg_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
      cfg_r     <= tos_pkg::CFG_RST;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r  <= hrdata_nxt;
      cfg_r     <= cfg_nxt;
    end
  end

  // area words have no reset; software fills them before a commit
  always_ff @(posedge hclk)
  begin
    if (area_hit)
      area_r[wr_addr_r[5:2]] <= hwdata;
  end

  // scan: one area word per cycle, stops at a queued end mark, a full queue or the configured area limit
  assign cur     = area_r[idx_r];
  assign cur_seq = cur[tos_pkg::F_SEQ_LSB +: 6];
  assign cur_end = cur[tos_pkg::F_END];

  always_comb
  begin
    st_nxt     = st_r;
    idx_nxt    = idx_r;
    exp_nxt    = exp_r;
    last_nxt   = last_r;
    bad_nxt    = bad_r;
    pushed_nxt = pushed_r;
    sts_nxt    = sts_r;
    q.push     = 1'b0;
    q.wdata    = cur;
    unique case (st_r)
      TOS_IDLE:
      begin
        if (commit_hit && !cfg_err)
        begin
          st_nxt     = TOS_SCAN;
          idx_nxt    = 4'h0;
          bad_nxt    = 1'b0;
          pushed_nxt = 1'b0;
        end
      end
      TOS_SCAN:
      begin
        idx_nxt = idx_r + 4'h1;
        if (cur_seq != exp_r)
          bad_nxt = 1'b1;
        else if (q.full)
        begin
          st_nxt  = TOS_IDLE;
          sts_nxt = tos_pkg::STS_FULL;
        end
        else
        begin
          q.push     = 1'b1;
          exp_nxt    = cur_seq + 6'h01;
          last_nxt   = cur_seq;
          pushed_nxt = 1'b1;
        end
        if (st_nxt == TOS_SCAN &&
            ((q.push && cur_end) || idx_r == limit - 4'h1))
        begin
          st_nxt = TOS_IDLE;
          if (bad_nxt)
            sts_nxt = tos_pkg::STS_SEQ;
          else if (!pushed_nxt)
            sts_nxt = tos_pkg::STS_NONE;
          else
            sts_nxt = tos_pkg::STS_OK;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r     <= TOS_IDLE;
      idx_r    <= 4'h0;
      exp_r    <= tos_pkg::SEQ_RST;
      last_r   <= 6'h00;
      bad_r    <= 1'b0;
      pushed_r <= 1'b0;
      sts_r    <= tos_pkg::STS_NONE;
    end
    else
    begin
      st_r     <= st_nxt;
      idx_r    <= idx_nxt;
      exp_r    <= exp_nxt;
      last_r   <= last_nxt;
      bad_r    <= bad_nxt;
      pushed_r <= pushed_nxt;
      sts_r    <= sts_nxt;
    end
  end

  // ticker, dequeue and channel outputs
  assign us_tick = (div_r == 5'(tos_pkg::US_CYCLES - 1));
  assign head_st = {q.head[tos_pkg::F_ST1], q.head[tos_pkg::F_ST0]};
  assign q.pop   = !q.empty &&
                   (q.head[tos_pkg::F_TIME_LSB +: 16] == us_cnt_r[15:0]);

  always_comb
  begin
    div_nxt     = us_tick ? 5'h00 : div_r + 5'h01;
    us_cnt_nxt  = us_tick ? us_cnt_r + 32'h1 : us_cnt_r;
    st_out_nxt  = q.pop ? head_st : st_out_r;
    en_out_nxt  = q.pop ? {q.head[tos_pkg::F_EN1], q.head[tos_pkg::F_EN0]}
                        : en_out_r;
    end_cnt_nxt = end_cnt_r + 6'(q.push && cur_end)
                  - 6'(q.pop && q.head[tos_pkg::F_END]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_r     <= 5'h00;
      us_cnt_r  <= 32'h0000_0000;
      st_out_r  <= 2'h0;
      en_out_r  <= 2'h0;
      end_cnt_r <= 6'h00;
    end
    else
    begin
      div_r     <= div_nxt;
      us_cnt_r  <= us_cnt_nxt;
      st_out_r  <= st_out_nxt;
      en_out_r  <= en_out_nxt;
      end_cnt_r <= end_cnt_nxt;
    end
  end

  // fault pins: a change counts once the second and third stages agree
  assign fault_any = |flt_r;

  always_comb
  begin
    flt_nxt    = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
    fl_cnt_nxt = fl_cnt_r;
    fl_ph_nxt  = fl_ph_r;
    if (us_tick)
    begin
      if (fl_cnt_r == 20'(FLASH_HALF_US - 1))
      begin
        fl_cnt_nxt = 20'h00000;
        fl_ph_nxt  = !fl_ph_r;
      end
      else
        fl_cnt_nxt = fl_cnt_r + 20'h00001;
    end
    // a real fault outranks a bad configuration: steady beats flashing
    mf_nxt = fault_any || (cfg_err && fl_ph_r);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r     <= 3'h0;
      s2_r     <= 3'h0;
      s3_r     <= 3'h0;
      flt_r    <= 3'h0;
      fl_cnt_r <= 20'h00000;
      fl_ph_r  <= 1'b0;
      mf_r     <= 1'b0;
    end
    else
    begin
      s1_r     <= {fault_overtemp, fault_short, fault_overload};
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      flt_r    <= flt_nxt;
      fl_cnt_r <= fl_cnt_nxt;
      fl_ph_r  <= fl_ph_nxt;
      mf_r     <= mf_nxt;
    end
  end

  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign hrdata                 = hrdata_r;
  assign do_state               = st_out_r;
  assign do_enable              = en_out_r;
  assign chan_led               = st_out_r;
  assign module_fault_indicator = mf_r;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_APPLY: assert property (
    q.pop |=> (do_state == $past(head_st)))
    else $error("dequeued state not applied");
  AST_LED: assert property (chan_led == do_state)
    else $error("indicator differs from output state");
  AST_NOFULL: assert property (q.push |-> !q.full)
    else $error("entry pushed into full queue");
  AST_SEQ: assert property (q.push |-> cur_seq == exp_r)
    else $error("non-following entry accepted");
  AST_END: assert property (
    (st_r == TOS_SCAN && q.push && cur_end) |=> st_r == TOS_IDLE)
    else $error("scan continued past end mark");
  AST_LIMIT: assert property ((st_r == TOS_SCAN) |-> idx_r < limit)
    else $error("scan beyond configured area");
  AST_STS: assert property (queue_status[6:2] == 5'h00)
    else $error("status code out of range");
  AST_TICK: assert property (
    us_tick |=> us_cnt_r == $past(us_cnt_r) + 32'h1 ##1 !us_tick [*8])
    else $error("ticker did not step once per microsecond");
  AST_FAULT: assert property (fault_any |=> module_fault_indicator)
    else $error("fault not shown");
  AST_CFG: assert property (
    (!fault_any && !cfg_err) |=> !module_fault_indicator)
    else $error("fault indicator lit without cause");

  COV_PUSH: cover property (q.push ##1 q.pop);
  COV_FULL: cover property (st_r == TOS_SCAN && q.full);
  COV_SEQ: cover property (sts_r == tos_pkg::STS_SEQ);
  COV_FLASH: cover property (cfg_err && module_fault_indicator);
endmodule // tos_top
`default_nettype wire

//--- testbench/tos_ctrl_model.sv
// partner model: bus controller issuing single AHB-Lite word transfers
`timescale 1ns/10ps
`default_nettype none
module tos_ctrl_model (
  input  wire logic        hclk,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  int tmo = 0;

  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // a stuck slave must not hang the run, so every wait has a bound
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1)
      tmo++;
  endtask

  // call just after a rising edge; returns just after the data phase edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    // released data lines must not keep looking valid
    hwdata <= ~d;
  endtask
endmodule // tos_ctrl_model
`default_nettype wire

//--- testbench/tb_top.sv
// testbench: self-checking bench of the timestamped output scheduler
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [2:0]  faults = 3'h0;
  logic [1:0]  do_state;
  logic [1:0]  do_enable;
  logic [1:0]  chan_led;
  logic        module_fault_indicator;
  int          miscompares = 0;
  int          checks = 0;

  always #20 hclk = ~hclk;

  tos_ctrl_model tos_ctrl_model_i (
    .hclk   (hclk),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize  (hsize),
    .hwdata (hwdata),
    .hready (hreadyout),
    .hrdata (hrdata)
  );

  tos_top #(.FLASH_HALF_US(4)) tos_top_i (
    .hclk                   (hclk),
    .hresetn                (hresetn),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (hsize),
    .hwdata                 (hwdata),
    .hready                 (hreadyout),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .hrdata                 (hrdata),
    .fault_overload         (faults[0]),
    .fault_short            (faults[1]),
    .fault_overtemp         (faults[2]),
    .do_state               (do_state),
    .do_enable              (do_enable),
    .chan_led               (chan_led),
    .module_fault_indicator (module_fault_indicator)
  );

  task automatic close_out();
    miscompares += tos_ctrl_model_i.tmo;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic limit(input int n, input int lim);
    if (n >= lim)
    begin
      miscompares++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    tos_ctrl_model_i.xfer(1'b1, a, d, q);
    limit(tos_ctrl_model_i.tmo, 1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    tos_ctrl_model_i.xfer(1'b0, a, 32'h0, q);
    limit(tos_ctrl_model_i.tmo, 1);
  endtask

  task automatic chk_sts(input logic [31:0] e);
    logic [31:0] q;
    rd(tos_pkg::OFS_STATUS, q);
    cmp32("status", e, q);
  endtask

  function automatic logic [31:0] ent(logic [3:0] st, logic [5:0] sq,
                                      logic em, logic [15:0] t);
    return {t, 1'b0, em, sq, st, 4'h0};
  endfunction

  function automatic logic [31:0] stat(logic [5:0] last, logic [5:0] nx,
                                       logic [7:0] s, logic [5:0] n);
    return {2'h0, n, s, tos_pkg::NEXT_TAG, nx, tos_pkg::LAST_TAG, last};
  endfunction

  // entry bits 7..4 land reversed on {enable, state}
  function automatic logic [31:0] outs(logic [3:0] st);
    return {28'h0, st[0], st[1], st[2], st[3]};
  endfunction

  initial
  begin
    logic [31:0] q;
    logic [31:0] t;
    logic [3:0]  st [0:15];
    logic [5:0]  sq [0:3];
    int          i;
    int          tg;
    sq = '{6'h02, 6'h05, 6'h03, 6'h04};
    void'($urandom(32'h73a625cd));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cmp32("outs_rst", 32'h0, {25'h0, module_fault_indicator, chan_led,
                              do_enable, do_state});
    rd(tos_pkg::OFS_TICK, q);
    cmp32("tick_start", 32'h1, {31'h0, q < 2});
    chk_sts(stat(6'h0, tos_pkg::SEQ_RST, tos_pkg::STS_NONE, 6'h0));
    rd(tos_pkg::OFS_CFG, q);
    cmp32("cfg_rst", {24'h0, tos_pkg::CFG_RST}, q);
    wr(8'h80, 32'hffffffff);
    rd(8'h80, q);
    cmp32("unmapped", 32'h0, q);
    cmp32("hresp", 32'h0, {31'h0, hresp});
    rd(tos_pkg::OFS_TICK, t);
    repeat (250) @(posedge hclk);
    rd(tos_pkg::OFS_TICK, q);
    cmp32("tick_rate", 32'h1, {31'h0, (q - t) inside {10, 11}});
    // one entry due shortly; a nonzero state makes the change visible
    st[0] = 4'($urandom) | 4'h8;
    rd(tos_pkg::OFS_TICK, t);
    wr(tos_pkg::OFS_AREA, ent(st[0], 6'h01, 1'b1, t[15:0] + 16'd30));
    wr(tos_pkg::OFS_COMMIT, 32'h0);
    repeat (18) @(posedge hclk);
    chk_sts(stat(6'h01, 6'h01, 8'h80, 6'h01));
    i = 0;
    while ({do_enable, do_state} === 4'h0 && i < 2000)
    begin
      @(posedge hclk);
      i++;
    end
    limit(i, 2000);
    rd(tos_pkg::OFS_TICK, q);
    cmp32("apply_time", 32'h1,
          {31'h0, (q[15:0] - t[15:0] - 16'd30) <= 16'd1});
    cmp32("apply_out", outs(st[0]), {28'h0, do_enable, do_state});
    cmp32("leds", outs(st[0]) & 32'h3, {30'h0, chan_led});
    rd(tos_pkg::OFS_STATUS, q);
    cmp32("count_deq", 32'h0, {25'h0, q[29:23]});
    // status is read after each batch; the second fifteen-entry batch fills the queue and its last entry is refused
    rd(tos_pkg::OFS_TICK, t);
    t[15:0] = t[15:0] + 16'd400;
    for (i = 0; i < 4; i++)
      wr(tos_pkg::OFS_AREA + 8'(4 * i),
         ent(4'($urandom), sq[i], i == 2, t[15:0]));
    wr(tos_pkg::OFS_COMMIT, 32'h0);
    repeat (18) @(posedge hclk);
    chk_sts(stat(6'h03, 6'h02, 8'h81, 6'h02));
    wr(tos_pkg::OFS_CFG, 32'h1);
    rd(tos_pkg::OFS_CFG, q);
    cmp32("cfg_large", 32'h1, q);
    for (int b = 0; b < 2; b++)
    begin
      for (i = 0; i < 15; i++)
      begin
        st[i] = 4'($urandom);
        // one entry per microsecond: a microsecond lasts only 25 clocks
        wr(tos_pkg::OFS_AREA + 8'(4 * i),
           ent(st[i], 6'(4 + 15 * b + i), 1'b0,
               t[15:0] + 16'(15 * b + i)));
      end
      wr(tos_pkg::OFS_COMMIT, 32'h0);
      repeat (18) @(posedge hclk);
      if (b == 0)
        chk_sts(stat(6'd18, 6'h02, 8'h80, 6'd17));
      else
        chk_sts(stat(6'd32, 6'h02, 8'h83, 6'd31));
    end
    i = 0;
    q = 32'hffffffff;
    while (q[29:24] !== 6'h0 && i < 6000)
    begin
      rd(tos_pkg::OFS_STATUS, q);
      i++;
    end
    limit(i, 6000);
    cmp32("drained", 32'h21, {19'h0, q[29:23], q[13:8]});
    cmp32("last_out", outs(st[13]), {28'h0, do_enable, do_state});
    wr(tos_pkg::OFS_CFG, 32'h0);
    for (i = 0; i < 6; i++)
      wr(tos_pkg::OFS_AREA + 8'(4 * i),
         ent(4'($urandom), 6'(33 + i), 1'b0, t[15:0]));
    wr(tos_pkg::OFS_COMMIT, 32'h0);
    repeat (18) @(posedge hclk);
    chk_sts(stat(6'd37, 6'd33, 8'h00, 6'd5));
    for (i = 0; i < 3; i++)
    begin
      faults <= 3'h1 << i;
      repeat (10) @(posedge hclk);
      cmp32("fault_on", 32'h1, {31'h0, module_fault_indicator});
      rd(tos_pkg::OFS_OUTS, q);
      cmp32("fault_bits", 32'h1 << i, {29'h0, q[8:6]});
      faults <= 3'h0;
      repeat (10) @(posedge hclk);
      cmp32("fault_off", 32'h0, {31'h0, module_fault_indicator});
    end
    // a bad configuration flashes the indicator and blocks commits
    wr(tos_pkg::OFS_CFG, 32'h2);
    wr(tos_pkg::OFS_COMMIT, 32'h0);
    tg = 0;
    for (i = 0; i < 400; i++)
    begin
      @(posedge hclk);
      if (module_fault_indicator !== tos_top_i.module_fault_indicator)
        tg += 100;
      q[0] = module_fault_indicator;
      @(negedge hclk);
      if (module_fault_indicator !== q[0])
        tg++;
    end
    cmp32("flash", 32'h1, {31'h0, tg inside {[3:5]}});
    @(posedge hclk);
    chk_sts(stat(6'd37, 6'd33, 8'h00, 6'd5));
    wr(tos_pkg::OFS_CFG, 32'h0);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
